//--- logic/repeater_cascade_arbitration.sv
// Cascade bus arbitration, shared lines and receive bit FIFO
// Functional notes
// - Cascade bus is eight lines: chain in/out, three shared flags, frame, data, clock.
// - Thirteen ports form one priority chain, port 1 highest, port 13 lowest.
// - Chain input enters at port 1; chain result leaves on chain output.
// - In idle, the source port is the highest port with receive or collision.
// - On leaving transmit collision, last-collision port is highest colliding port.
// - Holding the source port drives the chain output low.
// - Only the source or last-collision holder asserts source activity.
// - Collision on a non-held port asserts the other-port-collision line.
// - Only the holder asserts source collision while its port collides.
// - Only the source holder drives the data-frame enable.
// - Only the source holder drives NRZ data from its port.
// - Only the source holder drives the bus data clock.
// - Under parallel arbitration, idle receive activity asserts the chain output.
// - The same request and grant finds the last-collision holder.
`timescale 1ns/1ps

// ----------------------------------------
// Bit FIFO between bus sampling and the elasticity buffer
// ----------------------------------------
module cascade_bit_fifo #(
	parameter int unsigned WIDTH = cascade_pkg::RX_FIFO_WIDTH,
	parameter int unsigned DEPTH = cascade_pkg::RX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Filling side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Draining side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr;
		logic [PTR_W-1:0] rd;
		logic [PTR_W:0] cnt;
	} fifo_st_t;

	fifo_st_t st_r;
	fifo_st_t st_nxt;
	logic push;
	logic pop;

	// Wrap explicitly so depths other than powers of two work
	function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p);
		step_ptr = (p == LAST_PTR) ? '0 : p + 1'b1;
	endfunction

	// Flags come straight from the count, so full and empty never lie
	assign o_in_ready = (st_r.cnt != FULL_COUNT);
	assign o_out_valid = (st_r.cnt != '0);
	assign o_out_data = st_r.mem[st_r.rd];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Next pointers, count and storage
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr] = i_in_data;
			st_nxt.wr = step_ptr(st_r.wr);
		end
		if (pop) begin
			st_nxt.rd = step_ptr(st_r.rd);
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ----------------------------------------
// Top: port arbitration and cascade bus drivers
// ----------------------------------------
module repeater_cascade_arbitration #(
	parameter int unsigned PORTS = cascade_pkg::PORT_COUNT,
	parameter int unsigned FIFO_DEPTH = cascade_pkg::RX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Main state machine
	input wire cascade_pkg::rpt_state_t i_rpt_state,
	output cascade_pkg::mon_t o_mon,
	// Port state machines, asynchronous levels
	input wire logic [PORTS-1:0] i_port_rx_act,
	input wire logic [PORTS-1:0] i_port_col,
	// Local decoded stream, asynchronous
	input wire cascade_pkg::dec_in_t i_dec,
	// Cascade bus pins
	input wire cascade_pkg::bus_in_t i_bus,
	output cascade_pkg::bus_out_t o_bus,
	output cascade_pkg::bus_oe_t o_bus_oe_n,
	// Arbitration result
	output logic o_port_n_valid,
	output logic o_port_m_valid,
	output logic [cascade_pkg::PORT_IDX_W-1:0] o_hold_idx,
	// Received bus bits
	output logic o_rx_valid,
	output logic o_rx_bit,
	input wire logic i_rx_ready,
	output logic o_rx_overflow
);
	localparam int unsigned IDX_W = cascade_pkg::PORT_IDX_W;

	typedef struct packed {
		cascade_pkg::bus_in_t bus1;
		cascade_pkg::bus_in_t bus2;
		logic clk_d;
		logic [PORTS-1:0] act1;
		logic [PORTS-1:0] act2;
		logic [PORTS-1:0] col1;
		logic [PORTS-1:0] col2;
		cascade_pkg::dec_in_t dec1;
		cascade_pkg::dec_in_t dec2;
		cascade_pkg::rpt_state_t prev_state;
		cascade_pkg::hold_t hold;
		logic [IDX_W-1:0] idx;
		cascade_pkg::bus_out_t bus;
		cascade_pkg::bus_oe_t oe_n;
		cascade_pkg::mon_t mon;
		logic rx_valid;
		logic rx_bit;
		logic overflow;
		logic n_valid, m_valid;
	} st_t;

	st_t st_r;
	st_t st_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_bit;
	logic fifo_out_ready;
	logic rx_push;

	// Lowest index wins: index 0 is port 1, top of the chain
	function automatic logic [IDX_W-1:0] first_port(input logic [PORTS-1:0] v);
		first_port = '0;
		for (int i = PORTS - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_port = IDX_W'(i);
			end
		end
	endfunction

	// Bus bits sampled while another device sources the frame
	assign rx_push = st_r.bus2.bus_data_clock & ~st_r.clk_d & st_r.bus2.bus_data_frame
		& (st_r.hold != cascade_pkg::HOLD_SOURCE);
	assign fifo_out_ready = ~st_r.rx_valid | i_rx_ready;

	cascade_bit_fifo #(
		.WIDTH(cascade_pkg::RX_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_in_valid(rx_push),
		.i_in_data(st_r.bus2.bus_nrz_data),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_bit),
		.i_out_ready(fifo_out_ready)
	);

	// Next state: sync, arbitrate, drive the shared lines
	always_comb begin
		logic chain_free;
		logic leave_txcol;
		logic enter_idle;
		logic requesting;
		logic holder;
		logic [PORTS-1:0] req_src;
		logic [PORTS-1:0] other_col;
		chain_free = 1'b0;
		leave_txcol = 1'b0;
		enter_idle = 1'b0;
		requesting = 1'b0;
		holder = 1'b0;
		req_src = '0;
		other_col = '0;
		st_nxt = st_r;

		// Two flops on everything from outside this clock
		st_nxt.bus1 = i_bus;
		st_nxt.bus2 = st_r.bus1;
		st_nxt.act1 = i_port_rx_act;
		st_nxt.act2 = st_r.act1;
		st_nxt.col1 = i_port_col;
		st_nxt.col2 = st_r.col1;
		st_nxt.dec1 = i_dec;
		st_nxt.dec2 = st_r.dec1;
		st_nxt.clk_d = st_r.bus2.bus_data_clock;
		st_nxt.prev_state = i_rpt_state;

		// High chain input means no device above has won
		chain_free = st_r.bus2.arb_chain_in;
		req_src = st_r.act2 | st_r.col2;
		leave_txcol = (st_r.prev_state == cascade_pkg::RPT_TX_COL)
			&& (i_rpt_state != cascade_pkg::RPT_TX_COL);
		enter_idle = (st_r.prev_state != cascade_pkg::RPT_IDLE)
			&& (i_rpt_state == cascade_pkg::RPT_IDLE);

		// Holder state machine
		case (st_r.hold)
			cascade_pkg::HOLD_NONE: begin
				if (i_rpt_state == cascade_pkg::RPT_IDLE && chain_free && |req_src) begin
					st_nxt.hold = cascade_pkg::HOLD_SOURCE;
					st_nxt.idx = first_port(req_src);
				end else if (leave_txcol && chain_free && |st_r.col2) begin
					st_nxt.hold = cascade_pkg::HOLD_LAST_COL;
					st_nxt.idx = first_port(st_r.col2);
				end
			end
			cascade_pkg::HOLD_SOURCE, cascade_pkg::HOLD_LAST_COL: begin
				// Every exit from transmit collision re-arbitrates the last port
				if (leave_txcol) begin
					if (chain_free && |st_r.col2) begin
						st_nxt.hold = cascade_pkg::HOLD_LAST_COL;
						st_nxt.idx = first_port(st_r.col2);
					end else begin
						st_nxt.hold = cascade_pkg::HOLD_NONE;
					end
				end else if (enter_idle) begin
					st_nxt.hold = cascade_pkg::HOLD_NONE;
				end
			end
			default: begin
				st_nxt.hold = cascade_pkg::HOLD_NONE;
			end
		endcase

		holder = (st_nxt.hold != cascade_pkg::HOLD_NONE);
		st_nxt.n_valid = (st_nxt.hold == cascade_pkg::HOLD_SOURCE);
		st_nxt.m_valid = (st_nxt.hold == cascade_pkg::HOLD_LAST_COL);

		// Request in idle on any activity, in transmit collision on collisions
		if (i_rpt_state == cascade_pkg::RPT_IDLE) begin
			requesting = |req_src;
		end else if (i_rpt_state == cascade_pkg::RPT_TX_COL) begin
			requesting = |st_r.col2;
		end

		// Low passes down from above, or marks our own request or hold
		st_nxt.bus.arb_chain_out = (~chain_free | holder | requesting)
			? cascade_pkg::LINE_ASSERTED : cascade_pkg::LINE_RELEASED;

		// Shared flags only ever pull low, so several drivers never fight
		st_nxt.bus.source_activity = cascade_pkg::LINE_ASSERTED;
		st_nxt.bus.other_port_collision = cascade_pkg::LINE_ASSERTED;
		st_nxt.bus.source_collision = cascade_pkg::LINE_ASSERTED;
		st_nxt.oe_n.source_activity = (holder && req_src[st_nxt.idx])
			? cascade_pkg::DRIVE_ON_N : cascade_pkg::DRIVE_OFF_N;
		st_nxt.oe_n.source_collision = (holder && st_r.col2[st_nxt.idx])
			? cascade_pkg::DRIVE_ON_N : cascade_pkg::DRIVE_OFF_N;

		// Collisions on every port except the held one
		other_col = st_r.col2;
		if (holder) begin
			other_col[st_nxt.idx] = 1'b0;
		end
		st_nxt.oe_n.other_port_collision = (|other_col)
			? cascade_pkg::DRIVE_ON_N : cascade_pkg::DRIVE_OFF_N;

		// Data, frame and clock leave only from the source holder
		st_nxt.bus.bus_data_frame = st_r.dec2.valid;
		st_nxt.bus.bus_nrz_data = st_r.dec2.data;
		st_nxt.bus.bus_data_clock = st_r.dec2.clk;
		if (st_nxt.hold == cascade_pkg::HOLD_SOURCE) begin
			st_nxt.oe_n.bus_data_frame = cascade_pkg::DRIVE_ON_N;
			st_nxt.oe_n.bus_nrz_data = cascade_pkg::DRIVE_ON_N;
			st_nxt.oe_n.bus_data_clock = cascade_pkg::DRIVE_ON_N;
		end else begin
			st_nxt.oe_n.bus_data_frame = cascade_pkg::DRIVE_OFF_N;
			st_nxt.oe_n.bus_nrz_data = cascade_pkg::DRIVE_OFF_N;
			st_nxt.oe_n.bus_data_clock = cascade_pkg::DRIVE_OFF_N;
		end

		// Monitored wired-OR lines, turned active high
		st_nxt.mon.source_activity = ~st_r.bus2.source_activity;
		st_nxt.mon.other_port_collision = ~st_r.bus2.other_port_collision;
		st_nxt.mon.source_collision = ~st_r.bus2.source_collision;

		// Output stage; a lost bit beats the end-of-frame clear
		if (fifo_out_ready) begin
			st_nxt.rx_valid = fifo_out_valid;
			st_nxt.rx_bit = fifo_out_bit;
		end
		st_nxt.overflow = (st_r.overflow & st_r.bus2.bus_data_frame)
			| (rx_push & ~fifo_in_ready);
	end

	// State register; reset releases every shared line
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_r <= '0;
			st_r.oe_n <= '1;
			st_r.bus.arb_chain_out <= cascade_pkg::LINE_RELEASED;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign o_bus = st_r.bus;
	assign o_bus_oe_n = st_r.oe_n;
	assign o_mon = st_r.mon;
	assign o_port_n_valid = st_r.n_valid;
	assign o_port_m_valid = st_r.m_valid;
	assign o_hold_idx = st_r.idx;
	assign o_rx_valid = st_r.rx_valid;
	assign o_rx_bit = st_r.rx_bit;
	assign o_rx_overflow = st_r.overflow;
endmodule

//--- logic/cascade_pkg.sv
// Shared constants and types for the repeater cascade bus logic
package cascade_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int unsigned PORT_COUNT = 13;
	localparam int unsigned PORT_IDX_W = 4;
	localparam int unsigned RX_FIFO_DEPTH = 4;
	localparam int unsigned RX_FIFO_WIDTH = 1;

	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	localparam logic LINE_ASSERTED = 1'h0;
	localparam logic LINE_RELEASED = 1'h1;
	localparam logic DRIVE_ON_N = 1'h0;
	localparam logic DRIVE_OFF_N = 1'h1;

	// ----------------------------------------
	// Repeater states reported by the main state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		RPT_IDLE = 3'b000,
		RPT_REPEAT = 3'b001,
		RPT_RX_COL = 3'b010,
		RPT_TX_COL = 3'b011,
		RPT_ONE_LEFT = 3'b100,
		RPT_WAIT = 3'b101
	} rpt_state_t;

	// What this device holds on the cascade bus
	typedef enum logic [1:0] {
		HOLD_NONE = 2'b00,
		HOLD_SOURCE = 2'b01,
		HOLD_LAST_COL = 2'b10
	} hold_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	// Cascade bus lines as seen at the input buffers
	typedef struct packed {
		logic arb_chain_in;
		logic source_activity;
		logic other_port_collision;
		logic source_collision;
		logic bus_data_frame;
		logic bus_nrz_data;
		logic bus_data_clock;
	} bus_in_t;

	// Values presented on the cascade bus lines
	typedef struct packed {
		logic arb_chain_out;
		logic source_activity;
		logic other_port_collision;
		logic source_collision;
		logic bus_data_frame;
		logic bus_nrz_data;
		logic bus_data_clock;
	} bus_out_t;

	// Output enables of the shared lines, low while driving
	typedef struct packed {
		logic source_activity;
		logic other_port_collision;
		logic source_collision;
		logic bus_data_frame;
		logic bus_nrz_data;
		logic bus_data_clock;
	} bus_oe_t;

	// Decoded stream from the local decoder
	typedef struct packed {
		logic valid;
		logic data;
		logic clk;
	} dec_in_t;

	// Shared line levels, active high, for the main state machine
	typedef struct packed {
		logic source_activity;
		logic other_port_collision;
		logic source_collision;
	} mon_t;

endpackage

//--- bench/cascade_peer_model.sv
// Peer repeater controller and wire resolution of the cascade bus
`timescale 1ns/1ps

module cascade_peer_model (
	// Chain position
	input wire logic i_top,
	// Device side of the bus
	input wire cascade_pkg::bus_out_t i_dut,
	input wire cascade_pkg::bus_oe_t i_dut_oe_n,
	// Resolved wire levels
	output cascade_pkg::bus_in_t o_wire
);
	logic send_r = 1'b0;
	logic clk_r = 1'b0;
	logic dat_r = 1'b0;
	logic flip_r = 1'b0;

	// Undriven data line changes every cycle so a stale level never passes
	always #25 flip_r = ~flip_r;

	// Peer holds the source port and sends bits, MSB first, link clock 200 ns
	task automatic send(input logic [7:0] bits);
		int i;
		send_r = 1'b1;
		for (i = 7; i >= 0; i--) begin
			dat_r = bits[i];
			#100 clk_r = 1'b1;
			#100 clk_r = 1'b0;
		end
		#100 send_r = 1'b0;
	endtask

	// Pull-ups on flags, pull-downs on frame and clock; the clock stands outside frames
	always_comb begin
		// Peer above wins the grant while it sends, so our chain input drops
		o_wire.arb_chain_in = i_top | !send_r;
		o_wire.source_activity = !send_r & (i_dut_oe_n.source_activity | i_dut.source_activity);
		o_wire.other_port_collision = i_dut_oe_n.other_port_collision | i_dut.other_port_collision;
		o_wire.source_collision = i_dut_oe_n.source_collision | i_dut.source_collision;
		o_wire.bus_data_frame = i_dut_oe_n.bus_data_frame ? send_r : i_dut.bus_data_frame;
		o_wire.bus_nrz_data = !i_dut_oe_n.bus_nrz_data ? i_dut.bus_nrz_data : (send_r ? dat_r : flip_r);
		o_wire.bus_data_clock = i_dut_oe_n.bus_data_clock ? clk_r : i_dut.bus_data_clock;
	end
endmodule

//--- bench/repeater_cascade_arbitration_props.sv
// Concurrent checks on the cascade arbitration ports
`timescale 1ns/1ps

module repeater_cascade_arbitration_props #(
	parameter int unsigned PORTS = 13
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire cascade_pkg::rpt_state_t i_rpt_state,
	input wire logic [PORTS-1:0] i_port_rx_act,
	input wire logic [PORTS-1:0] i_port_col,
	input wire cascade_pkg::bus_in_t i_bus,
	input wire cascade_pkg::bus_out_t o_bus,
	input wire cascade_pkg::bus_oe_t o_bus_oe_n,
	input wire logic o_port_n_valid,
	input wire logic o_port_m_valid,
	input wire logic [3:0] o_hold_idx,
	input wire logic o_rx_valid,
	input wire logic o_rx_bit,
	input wire logic i_rx_ready,
	input wire logic o_rx_overflow
);
	logic [2:0] run_r;
	logic hold;
	assign hold = o_port_n_valid | o_port_m_valid;

	// Cycles since reset, so history checks skip the sync flush
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			run_r <= 3'h0;
		end else if (run_r != 3'h7) begin
			run_r <= run_r + 3'h1;
		end
	end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	a_chain_hold: assert property (o_port_n_valid |-> !o_bus.arb_chain_out)
		else $error("chain out high while holding source");
	a_lines_src: assert property (
		!(o_bus_oe_n.bus_data_frame & o_bus_oe_n.bus_nrz_data & o_bus_oe_n.bus_data_clock)
		|-> o_port_n_valid)
		else $error("frame data or clock driven without source");
	a_act_holder: assert property (!o_bus_oe_n.source_activity |-> hold)
		else $error("activity driven without a held port");
	a_col_holder: assert property (!o_bus_oe_n.source_collision |-> hold)
		else $error("source collision driven without a held port");
	a_idx_range: assert property (hold |-> o_hold_idx < PORTS)
		else $error("held index beyond last port");
	a_chain_refused: assert property (
		(run_r == 3'h7 && !i_bus.arb_chain_in) [*4]
		|=> !o_bus.arb_chain_out)
		else $error("chain low not passed down");
	a_idle_request: assert property (
		(i_rpt_state == cascade_pkg::RPT_IDLE && i_port_rx_act != '0) [*4]
		|=> !o_bus.arb_chain_out)
		else $error("idle activity gives no request");
	a_other_col: assert property (
		(run_r == 3'h7 && !o_bus_oe_n.other_port_collision)
		|-> ($past(i_port_col, 2) != '0 || $past(i_port_col, 3) != '0
		|| $past(i_port_col, 4) != '0))
		else $error("other collision without any port collision");
	a_rx_stall: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_bit))
		else $error("received bit lost while stalled");

	c_source: cover property (o_port_n_valid);
	c_last_col: cover property (o_port_m_valid);
	c_overflow: cover property (o_rx_overflow);
endmodule

bind repeater_cascade_arbitration repeater_cascade_arbitration_props #(.PORTS(PORTS)) props_u (
	.i_ref_clk, .i_rst, .i_rpt_state, .i_port_rx_act, .i_port_col, .i_bus, .o_bus,
	.o_bus_oe_n, .o_port_n_valid, .o_port_m_valid, .o_hold_idx, .o_rx_valid, .o_rx_bit,
	.i_rx_ready, .o_rx_overflow
);

//--- bench/repeater_cascade_arbitration_test.sv
// Self-checking bench for the cascade arbitration block
`timescale 1ns/1ps

module repeater_cascade_arbitration_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic top = 1'b1;
	logic rx_ready = 1'b1;
	logic [12:0] rx_act = '0;
	logic [12:0] col = '0;
	logic [12:0] pat;
	logic [31:0] seed = 32'h6d65_1d50;
	logic [31:0] ds = 32'h6d65_1d50;
	cascade_pkg::rpt_state_t state = cascade_pkg::RPT_IDLE;
	cascade_pkg::dec_in_t dec = '0;
	cascade_pkg::bus_in_t bus_in;
	cascade_pkg::bus_out_t bus_out;
	cascade_pkg::bus_oe_t oe_n;
	cascade_pkg::mon_t mon;
	logic n_v, m_v, rx_v, rx_b, ovf;
	logic [3:0] idx;
	int bad_count = 0;
	int compares = 0;
	int n, k, w;

	repeater_cascade_arbitration dut_u (
		.i_ref_clk(clk), .i_rst(rst), .i_rpt_state(state), .o_mon(mon),
		.i_port_rx_act(rx_act), .i_port_col(col), .i_dec(dec), .i_bus(bus_in),
		.o_bus(bus_out), .o_bus_oe_n(oe_n), .o_port_n_valid(n_v), .o_port_m_valid(m_v),
		.o_hold_idx(idx), .o_rx_valid(rx_v), .o_rx_bit(rx_b), .i_rx_ready(rx_ready),
		.o_rx_overflow(ovf)
	);
	cascade_peer_model peer_u (.i_top(top), .i_dut(bus_out), .i_dut_oe_n(oe_n), .o_wire(bus_in));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// Random local decoder stream, one step per cycle
	always @(posedge clk) begin
		#2;
		ds = lfsr_next(ds);
		dec = {1'b1, ds[0], ds[1]};
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Highest priority is the lowest bit
	function automatic logic [3:0] first_set(input logic [12:0] v);
		logic [3:0] r;
		r = 4'hf;
		for (int i = 12; i >= 0; i--) begin
			if (v[i]) r = i[3:0];
		end
		return r;
	endfunction

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#2;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		tick(6);
		rst = 1'b0;
		tick(4);
		// Source selection, other collision, last collision, release
		for (n = 0; n < 12; n++) begin
			seed = lfsr_next(seed);
			pat = (n == 0) ? 13'h1000 : (seed[12:0] | 13'h1000);
			rx_act = pat;
			tick(6);
			chk(n_v, 1);
			chk(idx, first_set(pat));
			chk(bus_out.arb_chain_out, 0);
			chk(oe_n.bus_data_frame, 0);
			chk(bus_out.bus_data_frame, 1);
			state = cascade_pkg::RPT_REPEAT;
			col = (first_set(pat) == 4'hc) ? 13'h0001 : 13'h1000;
			tick(5);
			chk(oe_n.other_port_collision, 0);
			chk(oe_n.source_collision, 1);
			// Monitored copy lags the pin by the two sync flops and one register
			tick(1);
			chk(mon.other_port_collision, 1);
			seed = lfsr_next(seed);
			pat = seed[12:0] | 13'h0400;
			state = cascade_pkg::RPT_TX_COL;
			col = pat;
			tick(5);
			state = cascade_pkg::RPT_ONE_LEFT;
			tick(3);
			chk(m_v, 1);
			chk(idx, first_set(pat));
			chk(oe_n.source_collision, 0);
			chk(oe_n.source_activity, 0);
			tick(2);
			chk(mon.source_collision, 1);
			chk(mon.source_activity, 1);
			rx_act = '0;
			col = '0;
			tick(4);
			state = cascade_pkg::RPT_IDLE;
			tick(3);
			chk(n_v | m_v, 0);
			chk(bus_out.arb_chain_out, 1);
		end
		// Peer frame upstream with a stalled drain, so the FIFO overflows
		top = 1'b0;
		rx_ready = 1'b0;
		fork
			peer_u.send(8'hb4);
			begin
				tick(12);
				chk(mon.source_activity, 1);
				chk(bus_out.arb_chain_out, 0);
				rx_act = 13'h0002;
				tick(6);
				chk(n_v, 0);
				rx_act = '0;
				tick(40);
				chk(ovf, 1);
			end
		join
		// Output stage plus four FIFO words keep the first five bits, the rest are lost
		for (k = 0; k < 5; k++) begin
			w = 0;
			while (rx_v !== 1'b1 && w < 20) begin
				tick(1);
				w++;
			end
			if (w == 20) begin
				bad_count++;
				results();
			end
			chk(rx_b, (8'hb4 >> (7 - k)) & 1);
			rx_ready = 1'b1;
			tick(1);
			rx_ready = 1'b0;
			tick(2);
		end
		chk(rx_v, 0);
		// Frame has ended, so the lost-bit flag must have cleared
		chk(ovf, 0);
		results();
	end
endmodule
